// >>> bench/dpfc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dpfc_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] partition_mode,
	input wire logic soft_swap_instruction,
	input wire logic cpu_idle,
	input wire logic second_partition_active,
	input wire logic swap_redirect,
	input wire logic boot_limit_locked,
	input wire logic regulator_standby,
	input wire logic flash_ready,
	input wire logic flash_start,
	input wire logic [3:0] flash_op,
	input wire logic [23:0] flash_addr,
	input wire logic flash_done,
	input wire logic flash_abort,
	input wire logic ram_req,
	input wire logic ram_underrun
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence wake_s;
		$past(regulator_standby) && !regulator_standby;
	endsequence
	sequence held_s;
		!flash_ready [*8];
	endsequence
	op_code_a: assert property (
		flash_start |-> flash_op inside {4'hE, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1})
		else $error("start with reserved code");
	one_start_a: assert property (flash_start |=>
		(!flash_start until (flash_done || flash_abort || ram_underrun)))
		else $error("second start while busy");
	limit_lock_a: assert property ($stable(partition_mode) |->
		boot_limit_locked == (partition_mode == 2'h2))
		else $error("limit lock wrong");
	prot_part_a: assert property (flash_start && partition_mode == 2'h1
		&& !(flash_op inside {4'h4, 4'hE}) |-> flash_addr[22] != second_partition_active)
		else $error("protected partition written");
	prot_bulk_a: assert property (flash_start && partition_mode == 2'h1 |->
		flash_op != 4'hE)
		else $error("protected bulk erase started");
	swap_jump_a: assert property (swap_redirect |-> $past(soft_swap_instruction, 2))
		else $error("redirect without swap");
	idle_stby_a: assert property (regulator_standby |-> cpu_idle || $past(cpu_idle))
		else $error("standby outside idle");
	wake_delay_a: assert property (wake_s |-> held_s)
		else $error("flash ready too early");
	row_fetch_a: assert property (ram_req |-> flash_op == 4'h2)
		else $error("fetch outside row program");
endmodule // dpfc_checker
`default_nettype wire

// >>> bench/dpfc_flash_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpfc_defines.vh"
module dpfc_flash_ctrl_bench;
	logic hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp, ok;
	logic [7:0] haddr;
	logic [1:0] htrans, partition_mode;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [23:0] boot_sequence_word_p1, boot_sequence_word_p2, flash_addr, ram_addr, got_addr, ram0;
	logic soft_swap_instruction, cpu_idle, second_partition_active, swap_redirect;
	logic boot_limit_locked, regulator_standby, flash_ready, flash_start, flash_done;
	logic flash_abort, ram_req, row_data_compressed, ram_valid, ram_underrun;
	logic fail_abort, fail_underrun, got_comp;
	logic [3:0] flash_op, got_op;
	int num_errors = 0, n_compared = 0, n_start = 0, cyc = 0;
	assign hready = hreadyout;
	dpfc_flash_ctrl i_dpfc_flash_ctrl (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .boot_sequence_word_p1,
		.boot_sequence_word_p2, .soft_swap_instruction, .cpu_idle, .partition_mode,
		.second_partition_active, .swap_redirect, .boot_limit_locked, .regulator_standby,
		.flash_ready, .flash_start, .flash_op, .flash_addr, .flash_done, .flash_abort, .ram_req,
		.ram_addr, .row_data_compressed, .ram_valid, .ram_underrun);
	dpfc_flash_model i_dpfc_flash_model (.hclk, .hresetn, .flash_start, .ram_req, .fail_abort,
		.fail_underrun, .flash_done, .flash_abort, .ram_valid, .ram_underrun);
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		chk(hresp, 0);
	endtask
	task automatic t_boot(input logic [11:0] s1, s2, input logic v1, v2, e);
		boot_sequence_word_p1 <= v1 ? {~s1, s1} : {s1, s1};
		boot_sequence_word_p2 <= v2 ? {~s2, s2} : {s2, s2};
		hresetn <= 1'b0;
		por_n <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(second_partition_active, e);
		bus(1'b0, `DPFC_ADDR_CTRL, 0);
		chk(q[10], e);
		$display("boot test done");
	endtask
	task automatic key;
		bus(1'b1, `DPFC_ADDR_KEY, `DPFC_KEY1);
		bus(1'b1, `DPFC_ADDR_KEY, `DPFC_KEY2);
	endtask
	task automatic t_op(input logic [15:0] c, input logic [23:0] a, input logic k, st, er);
		int n0;
		n0 = n_start;
		bus(1'b1, `DPFC_ADDR_DEST_HI, a[23:16]);
		bus(1'b1, `DPFC_ADDR_DEST_LO, a[15:0]);
		if (k)
			key();
		bus(1'b1, `DPFC_ADDR_CTRL, c);
		do bus(1'b0, `DPFC_ADDR_CTRL, 0); while (q[15] !== 1'b0);
		chk(n_start - n0, st);
		if (st) begin
			chk(got_op, c[3:0]);
			chk(got_addr, a);
		end
		if (st && c[3:0] == `DPFC_OP_ROW) begin
			chk(ram0, 24'h051230);
			chk(got_comp, c[9]);
		end
		chk(q[13], er);
		chk(q[8], fail_underrun);
		bus(1'b1, `DPFC_ADDR_CTRL, 0);
		bus(1'b0, `DPFC_ADDR_CTRL, 0);
		chk(q & 32'h2100, 0);
		$display("operation test done");
	endtask
	task automatic t_swap(input logic k);
		logic p;
		p = second_partition_active;
		if (k)
			key();
		soft_swap_instruction <= 1'b1;
		@(posedge hclk);
		soft_swap_instruction <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
		chk(swap_redirect, k);
		repeat (3) @(posedge hclk);
		chk(second_partition_active, p ^ k);
		bus(1'b0, `DPFC_ADDR_CTRL, 0);
		chk(q[11:10], {k, p ^ k});
		bus(1'b1, `DPFC_ADDR_SWAP, 1);
		bus(1'b0, `DPFC_ADDR_SWAP, 0);
		chk(q[0], 0);
		$display("swap test done");
	endtask
	task automatic t_idle;
		bus(1'b1, `DPFC_ADDR_CTRL, 32'h1000);
		cpu_idle <= 1'b1;
		repeat (5) @(posedge hclk);
		chk(regulator_standby, 1);
		cpu_idle <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(regulator_standby, 0);
		chk(flash_ready, 0);
		repeat (44) @(posedge hclk);
		chk(flash_ready, 0);
		repeat (16) @(posedge hclk);
		chk(flash_ready, 1);
		$display("idle test done");
	endtask
	task automatic t_misc;
		partition_mode <= 2'h2;
		repeat (3) @(posedge hclk);
		chk(boot_limit_locked, 1);
		bus(1'b0, `DPFC_ADDR_MODE, 0);
		chk(q[2:0], 3'h6);
		partition_mode <= 2'h0;
		bus(1'b0, 8'h20, 0);
		chk(q, 0);
		$display("misc test done");
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
		if (flash_start) begin
			n_start <= n_start + 1;
			got_op <= flash_op;
			got_addr <= flash_addr;
			ram0 <= 24'hFFFFFF;
		end else if (ram_req && ram0 === 24'hFFFFFF) begin
			ram0 <= ram_addr;
			got_comp <= row_data_compressed;
		end
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, soft_swap_instruction, cpu_idle} = '0;
		{partition_mode, fail_abort, fail_underrun, hresetn, por_n} = '0;
		{boot_sequence_word_p1, boot_sequence_word_p2} = '0;
		hsize = 3'h2;
		t_boot(12'h005, 12'h003, 1'b1, 1'b1, 1'b1);
		t_boot(12'h005, 12'h007, 1'b0, 1'b1, 1'b1);
		t_boot(12'h002, 12'h009, 1'b1, 1'b0, 1'b0);
		t_boot(12'h005, 12'h005, 1'b0, 1'b0, 1'b0);
		t_boot(12'h003, 12'h005, 1'b1, 1'b1, 1'b0);
		bus(1'b1, `DPFC_ADDR_SRC_LO, 32'h1230);
		bus(1'b1, `DPFC_ADDR_SRC_HI, 32'h05);
		for (int i = 0; i < 16; i++) begin
			ok = i inside {1, 2, 3, 4, 8, 14};
			t_op(16'hC200 | i[15:0], 24'h412344, 1'b1, ok, !ok);
		end
		t_op(16'h8001, 24'h412344, 1'b1, 1'b0, 1'b1);
		t_op(16'hC001, 24'h412344, 1'b0, 1'b0, 1'b1);
		fail_abort <= 1'b1;
		t_op(16'hC003, 24'h412344, 1'b1, 1'b1, 1'b1);
		fail_abort <= 1'b0;
		fail_underrun <= 1'b1;
		t_op(16'hC002, 24'h412344, 1'b1, 1'b1, 1'b1);
		fail_underrun <= 1'b0;
		partition_mode <= 2'h1;
		t_op(16'hC001, 24'h012344, 1'b1, 1'b0, 1'b1);
		t_op(16'hC001, 24'h412344, 1'b1, 1'b1, 1'b0);
		t_misc();
		t_swap(1'b0);
		t_swap(1'b1);
		t_idle();
		conclude();
	end
endmodule // dpfc_flash_ctrl_bench
bind dpfc_flash_ctrl dpfc_checker i_dpfc_checker (.hclk, .hresetn, .partition_mode,
	.soft_swap_instruction, .cpu_idle, .second_partition_active, .swap_redirect,
	.boot_limit_locked, .regulator_standby, .flash_ready, .flash_start, .flash_op, .flash_addr,
	.flash_done, .flash_abort, .ram_req, .ram_underrun);
`default_nettype wire

// >>> bench/dpfc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpfc_flash_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic flash_start,
	input wire logic ram_req,
	input wire logic fail_abort,
	input wire logic fail_underrun,
	output logic flash_done,
	output logic flash_abort,
	output logic ram_valid,
	output logic ram_underrun
);
	logic busy;
	logic [3:0] cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{busy, cnt, flash_done, flash_abort, ram_valid, ram_underrun} <= '0;
		end else begin
			flash_done <= 1'b0;
			flash_abort <= 1'b0;
			ram_underrun <= 1'b0;
			// Slow source: one word every other cycle
			ram_valid <= busy && ram_req && !ram_valid && !fail_underrun;
			if (flash_start) begin
				busy <= 1'b1;
				cnt <= 4'h0;
			end else if (busy && ram_req && fail_underrun) begin
				busy <= 1'b0;
				ram_underrun <= 1'b1;
			end else if (busy && !ram_req) begin
				cnt <= cnt + 4'h1;
				if (cnt == 4'h7) begin
					busy <= 1'b0;
					flash_done <= !fail_abort;
					flash_abort <= fail_abort;
				end
			end
		end
	end
endmodule // dpfc_flash_model
`default_nettype wire

// >>> design/dpfc_boot_select.v
`timescale 1ns/1ps
`default_nettype none
`include "dpfc_defines.vh"

module dpfc_boot_select (
	input wire hclk,
	input wire hresetn,
	input wire [23:0] boot_sequence_word_p1,
	input wire [23:0] boot_sequence_word_p2,
	output reg sel_p2,
	output reg done
);

	wire valid1;
	wire valid2;
	wire next_sel;

	assign valid1 = (boot_sequence_word_p1[23:12] == ~boot_sequence_word_p1[11:0]);
	assign valid2 = (boot_sequence_word_p2[23:12] == ~boot_sequence_word_p2[11:0]);
	assign next_sel = valid2 && (!valid1 ||
		boot_sequence_word_p2[11:0] < boot_sequence_word_p1[11:0]);

	// Sample straps once after reset release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_p2 <= 1'b0;
			done <= 1'b0;
		end else if (!done) begin
			sel_p2 <= next_sel;
			done <= 1'b1;
		end
	end

endmodule // dpfc_boot_select
`default_nettype wire

// >>> design/dpfc_flash_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dpfc_defines.vh"
// Notes on behaviour
// - Inactive partition operations never stall active-partition fetches.
// - Inactive partition programmed at active address plus 0x400000.
// - Boot word valid only when upper 12 bits complement lower 12.
// - At reset the lower valid sequence number picks active partition.
// - One valid number wins; none valid selects partition 1.
// - Unlocked soft swap exchanges partitions; jump lands in new partition (the code ignores a swap while Go bit 15 is set).
// - Swap keeps peripherals, RAM, stack; configuration ignored during swap.
// - Write 0x55 then 0xAA to key register before start or swap.
// - Swap without unlock does nothing; jump stays in current partition.
// - Swap-done bit 11 set by hardware, cleared by software.
// - Bit 10 reads 1 when partition 2 is active.
// - Protected mode refuses all operations targeting partition 1.
// - Privileged mode blocks boot segment limit changes.
// - Destination address: high register bits 23-16, low register 15-0.
// - Row program fetches data from RAM at source address.
// - Go bit 15 set by software only; cleared by hardware at end.
// - Enable bit 14 permits operations; those bits reset only at power-on.
// - Error bit 13 set on bad sequence or termination, clear on success.
// - Idle-standby bit 12 parks regulator in idle; wake waits a delay.
// - Bit 9 selects compressed row data format.
// - Underrun bit 8 set on row termination by RAM underrun, software clearable.
// - Operation codes E,8,4,3,2,1 valid; others reserved.

module dpfc_flash_ctrl (
	input wire hclk,
	input wire hresetn,
	input wire por_n,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [23:0] boot_sequence_word_p1,
	input wire [23:0] boot_sequence_word_p2,
	input wire soft_swap_instruction,
	input wire cpu_idle,
	input wire [1:0] partition_mode,
	output reg second_partition_active,
	output reg swap_redirect,
	output reg boot_limit_locked,
	output reg regulator_standby,
	output reg flash_ready,
	output reg flash_start,
	output reg [3:0] flash_op,
	output reg [23:0] flash_addr,
	input wire flash_done,
	input wire flash_abort,
	output reg ram_req,
	output reg [23:0] ram_addr,
	output reg row_data_compressed,
	input wire ram_valid,
	input wire ram_underrun
);

	// ----------------------------------------
	// State encoding
	// ----------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_ROW = 3'b100;

	reg [2:0] state;
	reg go;
	reg prog_erase_enable;
	reg sequence_error_flag;
	reg regulator_idle_standby;
	reg soft_swap_done;
	reg row_underrun_error;
	reg [3:0] operation_select;
	reg [15:0] dest_address_low;
	reg [7:0] dest_address_high;
	reg [15:0] src_lo;
	reg [7:0] src_hi;
	reg [7:0] row_count;
	reg [7:0] wake_count;
	reg ap_valid;
	reg ap_write;
	reg [7:0] ap_addr;
	reg swap_pending;
	reg boot_taken;

	wire [15:0] ctrl_read;
	wire unlocked;
	wire boot_sel_p2;
	wire boot_done;
	wire wr_fire;
	wire ctrl_wr;
	wire key_wr;
	wire op_valid;
	wire [23:0] dest_ea;
	wire targets_p1;
	wire start_ok;
	wire start_try;
	wire do_swap;
	wire [31:0] vreg_cycles;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	dpfc_boot_select i_dpfc_boot_select (
		.hclk(hclk),
		.hresetn(hresetn),
		.boot_sequence_word_p1(boot_sequence_word_p1),
		.boot_sequence_word_p2(boot_sequence_word_p2),
		.sel_p2(boot_sel_p2),
		.done(boot_done)
	);

	dpfc_unlock i_dpfc_unlock (
		.hclk(hclk),
		.hresetn(hresetn),
		.key_write(key_wr),
		.key_data(hwdata[7:0]),
		.other_write(wr_fire && !key_wr),
		.consume(start_try || soft_swap_instruction),
		.unlocked(unlocked)
	);

	// ----------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
		end else if (hready) begin
			ap_valid <= hsel && htrans[1];
			ap_write <= hwrite;
			ap_addr <= haddr;
		end
	end

	assign wr_fire = ap_valid && ap_write;
	assign ctrl_wr = wr_fire && (ap_addr == `DPFC_ADDR_CTRL);
	assign key_wr = wr_fire && (ap_addr == `DPFC_ADDR_KEY);

	assign dest_ea = {dest_address_high, dest_address_low};
	assign op_valid = (hwdata[3:0] == `DPFC_OP_BULK) ||
		(hwdata[3:0] == `DPFC_OP_BOOTDW) || (hwdata[3:0] == `DPFC_OP_INACT) ||
		(hwdata[3:0] == `DPFC_OP_PAGE) || (hwdata[3:0] == `DPFC_OP_ROW) ||
		(hwdata[3:0] == `DPFC_OP_DW);
	// Physical partition 1 is hit when active region addresses it while p1 is active,
	// when the inactive window addresses it while p2 is active, or on bulk erase.
	assign targets_p1 = (hwdata[3:0] == `DPFC_OP_BULK) ||
		((hwdata[3:0] == `DPFC_OP_INACT) ? second_partition_active :
		(dest_ea[22] ? second_partition_active : !second_partition_active));
	assign start_try = ctrl_wr && hwdata[`DPFC_BIT_GO] && !go && state == ST_IDLE;
	assign start_ok = start_try && unlocked && hwdata[`DPFC_BIT_PROGRAM_ERASE_ENABLE] && op_valid &&
		!(partition_mode == `DPFC_MODE_PROT && targets_p1);
	assign do_swap = soft_swap_instruction && unlocked;
	assign vreg_cycles = `DPFC_VREG_CYC;

	// ----------------------------------------
	// Control register and sequencer
	// ----------------------------------------
	always @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			go <= 1'b0;
			prog_erase_enable <= 1'b0;
			sequence_error_flag <= 1'b0;
			operation_select <= 4'h0;
			state <= ST_IDLE;
			flash_start <= 1'b0;
			flash_op <= 4'h0;
			flash_addr <= 24'h000000;
			ram_req <= 1'b0;
			ram_addr <= 24'h000000;
			row_count <= 8'h00;
			row_underrun_error <= 1'b0;
		end else begin
			flash_start <= 1'b0;
			if (ctrl_wr && state == ST_IDLE) begin
				prog_erase_enable <= hwdata[`DPFC_BIT_PROGRAM_ERASE_ENABLE];
				operation_select <= hwdata[3:0];
				if (!hwdata[`DPFC_BIT_UNDERRUN])
					row_underrun_error <= 1'b0;
				if (!hwdata[`DPFC_BIT_SEQERR])
					sequence_error_flag <= 1'b0;
			end
			case (state)
			ST_IDLE: begin
				if (start_ok) begin
					go <= 1'b1;
					sequence_error_flag <= 1'b0;
					flash_start <= 1'b1;
					flash_op <= hwdata[3:0];
					flash_addr <= dest_ea;
					if (hwdata[3:0] == `DPFC_OP_ROW) begin
						state <= ST_ROW;
						ram_req <= 1'b1;
						ram_addr <= {src_hi, src_lo};
						row_count <= `DPFC_ROW_WORDS;
					end else begin
						state <= ST_RUN;
					end
				end else if (start_try) begin
					sequence_error_flag <= 1'b1;
				end
			end
			ST_RUN: begin
				if (flash_abort) begin
					go <= 1'b0;
					sequence_error_flag <= 1'b1;
					state <= ST_IDLE;
				end else if (flash_done) begin
					go <= 1'b0;
					state <= ST_IDLE;
				end
			end
			ST_ROW: begin
				if (ram_underrun || flash_abort) begin
					go <= 1'b0;
					ram_req <= 1'b0;
					sequence_error_flag <= 1'b1;
					row_underrun_error <= row_underrun_error | ram_underrun;
					state <= ST_IDLE;
				end else if (ram_valid) begin
					ram_addr <= ram_addr + 24'h000004;
					flash_addr <= flash_addr + 24'h000004;
					row_count <= row_count - 8'h01;
					if (row_count == 8'h01) begin
						ram_req <= 1'b0;
						go <= 1'b0;
						state <= ST_IDLE;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Address, source and loose control bits
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest_address_low <= 16'h0000;
			dest_address_high <= 8'h00;
			src_lo <= 16'h0000;
			src_hi <= 8'h00;
			regulator_idle_standby <= 1'b0;
			row_data_compressed <= 1'b0;
		end else if (wr_fire && state == ST_IDLE) begin
			if (ap_addr == `DPFC_ADDR_DEST_LO)
				dest_address_low <= hwdata[15:0];
			else if (ap_addr == `DPFC_ADDR_DEST_HI)
				dest_address_high <= hwdata[7:0];
			else if (ap_addr == `DPFC_ADDR_SRC_LO)
				src_lo <= hwdata[15:0];
			else if (ap_addr == `DPFC_ADDR_SRC_HI)
				src_hi <= hwdata[7:0];
			else if (ap_addr == `DPFC_ADDR_CTRL) begin
				regulator_idle_standby <= hwdata[`DPFC_BIT_IDLESTBY];
				row_data_compressed <= hwdata[`DPFC_BIT_COMPRESS];
			end
		end
	end

	// ----------------------------------------
	// Partition mapping and soft swap
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			second_partition_active <= 1'b0;
			soft_swap_done <= 1'b0;
			swap_redirect <= 1'b0;
			boot_taken <= 1'b0;
			swap_pending <= 1'b0;
			boot_limit_locked <= 1'b0;
		end else begin
			swap_redirect <= 1'b0;
			boot_limit_locked <= (partition_mode == `DPFC_MODE_PRIV);
			if (boot_done && !boot_taken) begin
				second_partition_active <= boot_sel_p2;
				boot_taken <= 1'b1;
			end else if (do_swap && !go) begin
				// Configuration and peripheral state untouched by the swap
				second_partition_active <= !second_partition_active;
				swap_pending <= 1'b1;
			end
			if (swap_pending) begin
				swap_redirect <= 1'b1;
				swap_pending <= 1'b0;
			end
			if (swap_pending)
				soft_swap_done <= 1'b1;
			else if (wr_fire && ap_addr == `DPFC_ADDR_SWAP && hwdata[0])
				soft_swap_done <= 1'b0;
		end
	end

	// ----------------------------------------
	// Regulator idle standby
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regulator_standby <= 1'b0;
			flash_ready <= 1'b0;
			wake_count <= 8'h00;
		end else begin
			regulator_standby <= cpu_idle && regulator_idle_standby;
			if (cpu_idle && regulator_idle_standby) begin
				flash_ready <= 1'b0;
				wake_count <= vreg_cycles[7:0];
			end else if (wake_count != 8'h00) begin
				wake_count <= wake_count - 8'h01;
				flash_ready <= (wake_count == 8'h01);
			end else begin
				flash_ready <= boot_taken;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	assign ctrl_read = {go, prog_erase_enable, sequence_error_flag, regulator_idle_standby,
		soft_swap_done, second_partition_active, row_data_compressed, row_underrun_error,
		4'h0, operation_select};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				if (haddr == `DPFC_ADDR_CTRL)
					hrdata <= {16'h0000, ctrl_read};
				else if (haddr == `DPFC_ADDR_DEST_LO)
					hrdata <= {16'h0000, dest_address_low};
				else if (haddr == `DPFC_ADDR_DEST_HI)
					hrdata <= {24'h000000, dest_address_high};
				else if (haddr == `DPFC_ADDR_SRC_LO)
					hrdata <= {16'h0000, src_lo};
				else if (haddr == `DPFC_ADDR_SRC_HI)
					hrdata <= {24'h000000, src_hi};
				else if (haddr == `DPFC_ADDR_SWAP)
					hrdata <= {31'h00000000, soft_swap_done};
				else if (haddr == `DPFC_ADDR_MODE)
					hrdata <= {29'h00000000, boot_limit_locked, partition_mode};
				else
					hrdata <= 32'h00000000;
			end
		end
	end

endmodule // dpfc_flash_ctrl
`default_nettype wire

// >>> design/dpfc_unlock.v
`timescale 1ns/1ps
`default_nettype none
`include "dpfc_defines.vh"

module dpfc_unlock (
	input wire hclk,
	input wire hresetn,
	input wire key_write,
	input wire [7:0] key_data,
	input wire other_write,
	input wire consume,
	output reg unlocked
);

	reg got_first;

	// Two consecutive key writes arm; any other write disarms
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			got_first <= 1'b0;
			unlocked <= 1'b0;
		end else if (key_write) begin
			got_first <= (key_data == `DPFC_KEY1);
			unlocked <= got_first && (key_data == `DPFC_KEY2);
		end else if (other_write || consume) begin
			got_first <= 1'b0;
			unlocked <= 1'b0;
		end
	end

endmodule // dpfc_unlock
`default_nettype wire

// >>> shared/dpfc_defines.vh
`ifndef DPFC_DEFINES_VH
`define DPFC_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DPFC_ADDR_CTRL 8'h00
`define DPFC_ADDR_KEY 8'h04
`define DPFC_ADDR_DEST_LO 8'h08
`define DPFC_ADDR_DEST_HI 8'h0C
`define DPFC_ADDR_SRC_LO 8'h10
`define DPFC_ADDR_SRC_HI 8'h14
`define DPFC_ADDR_SWAP 8'h18
`define DPFC_ADDR_MODE 8'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DPFC_BIT_GO 15
`define DPFC_BIT_PROGRAM_ERASE_ENABLE 14
`define DPFC_BIT_SEQERR 13
`define DPFC_BIT_IDLESTBY 12
`define DPFC_BIT_SWAPDONE 11
`define DPFC_BIT_P2ACT 10
`define DPFC_BIT_COMPRESS 9
`define DPFC_BIT_UNDERRUN 8
`define DPFC_CTRL_RESET 16'h0000

// ----------------------------------------
// Unlock keys and operations
// ----------------------------------------
`define DPFC_KEY1 8'h55
`define DPFC_KEY2 8'hAA
`define DPFC_OP_BULK 4'hE
`define DPFC_OP_BOOTDW 4'h8
`define DPFC_OP_INACT 4'h4
`define DPFC_OP_PAGE 4'h3
`define DPFC_OP_ROW 4'h2
`define DPFC_OP_DW 4'h1

// ----------------------------------------
// Partition and mode constants
// ----------------------------------------
`define DPFC_INACT_OFFSET 24'h400000
`define DPFC_MODE_PLAIN 2'h0
`define DPFC_MODE_PROT 2'h1
`define DPFC_MODE_PRIV 2'h2
`define DPFC_ROW_WORDS 8'h40
`define DPFC_VREG_NS 1000
`define DPFC_CLK_NS 20
`define DPFC_VREG_CYC ((`DPFC_VREG_NS + `DPFC_CLK_NS - 1) / `DPFC_CLK_NS)

`endif
